/* core/arc_pkg.sv */
// Constants, codes and register map for the acquisition run control block.
// Assumes a single 100 MHz clock domain shared with the host register port.
// How it works
// - Post-trigger accepted up to 128M, 64M or 32M samples for 1, 2, 4 channels.
// - Memory size and post-trigger snap to granularity multiples, granularity being the minimum.
// - Granularity 32 for one channel or 0+2, 16 for four, 0+1 16 or 32.
// - Command code 10 at index 0 launches and loads the pending setup.
// - Command code 20 halts any running acquisition immediately.
// - Relay variants wait a programmed settling time after launch before sampling.
// - Status at index 10 reads 0 armed, 10 triggered, 20 stopped.
// - Acquisition stops by itself after the post-trigger samples are stored.
// - Command code 11 launches and raises an interrupt on completion.
// - Timeout register holds milliseconds for the interrupt launch; zero waits forever.
// - Samples go to two memory channels 0 and 1, distinct from inputs.
// - Two single-channel-module variants fill each memory channel sequentially.
// - Other variants: channel 0 sequential; channels 0 and 1 alternate into memory 0.
// - Channels 0 and 2 separate; four channels alternate 0/1 and 2/3.
// - Interlace runs channel 0 alone using two converters, standard mode only.
// - Interlace: odd samples to memory 0, even samples to memory 1.
// - Ring buffer until trigger, then post-trigger count; pretrigger is size minus post.
// - Trigger detection stays disarmed until the pretrigger portion is filled.
package arc_pkg;
    localparam logic [31:0] ARC_IDX_COMMAND = 32'h0000_0000;
    localparam logic [31:0] ARC_IDX_STATUS = 32'h0000_000A;
    localparam logic [31:0] ARC_IDX_TIMEOUT = 32'h0004_80DA;
    localparam logic [31:0] ARC_IDX_MEMSIZE = 32'h0000_2710;
    localparam logic [31:0] ARC_IDX_POSTTRIG = 32'h0000_2774;
    localparam logic [31:0] ARC_IDX_CHENABLE = 32'h0000_2AF8;
    localparam logic [31:0] ARC_IDX_SETTLE = 32'h0000_2B5C;
    localparam logic [31:0] ARC_IDX_MODE = 32'h0000_2BC0;
    localparam logic [31:0] ARC_LAUNCH_CODE = 32'h0000_000A;
    localparam logic [31:0] ARC_LAUNCH_IRQ_CODE = 32'h0000_000B;
    localparam logic [31:0] ARC_HALT_CODE = 32'h0000_0014;
    localparam logic [31:0] ARC_ARMED_STATE = 32'h0000_0000;
    localparam logic [31:0] ARC_TRIGGERED_STATE = 32'h0000_000A;
    localparam logic [31:0] ARC_FINISHED_STATE = 32'h0000_0014;
    localparam logic [31:0] ARC_MAX_POST_1CH = 32'h0800_0000;
    localparam logic [31:0] ARC_MAX_POST_2CH = 32'h0400_0000;
    localparam logic [31:0] ARC_MAX_POST_4CH = 32'h0200_0000;
    localparam logic [31:0] ARC_GRAN_32 = 32'h0000_0020;
    localparam logic [31:0] ARC_GRAN_16 = 32'h0000_0010;
    localparam logic [3:0] ARC_CH_0 = 4'h1;
    localparam logic [3:0] ARC_CH_01 = 4'h3;
    localparam logic [3:0] ARC_CH_02 = 4'h5;
    localparam logic [3:0] ARC_CH_ALL = 4'hF;
    localparam logic [31:0] ARC_RST_MEMSIZE = 32'h0000_0400;
    localparam logic [31:0] ARC_RST_POST = 32'h0000_0200;
    localparam int ARC_CLK_MHZ = 100;
    localparam int ARC_MS_CYCLES = ARC_CLK_MHZ * 1000;
    localparam int ARC_FIFO_DEPTH = 16;
    typedef enum logic [4:0] {
        ARC_ST_IDLE = 5'h01,
        ARC_ST_SETTLE = 5'h02,
        ARC_ST_PRE = 5'h04,
        ARC_ST_ARMED = 5'h08,
        ARC_ST_POST = 5'h10
    } arc_state_t;
endpackage

/* core/arc_fifo.sv */
// Small synchronous FIFO between the sample router and memory writer.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module arc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic push, pop;
    assign in_ready_out = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
    assign out_valid_out = wr_ptr != rd_ptr;
    assign out_data_out = mem[rd_ptr[AW-1:0]];
    always_comb begin
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end
endmodule
`default_nettype wire

/* core/arc_run_control.sv */
// Run control, setup registers and memory-channel routing of the digitizer.
// Assumes the host register port and sample stream share ref_clk_in; trigger is a pin.
`timescale 1ns/100ps
`default_nettype none
module arc_run_control
    import arc_pkg::*;
#(
    parameter bit SINGLE_MODULES = 1'b0,
    parameter bit HAS_RELAYS = 1'b1,
    parameter bit HAS_INTERLACE = 1'b1,
    parameter int MS_CYCLES = ARC_MS_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_index_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    input wire logic trigger_in,
    input wire logic sample_valid_in,
    input wire logic [47:0] sample_data_in,
    output logic mem_valid_out,
    input wire logic mem_ready_in,
    output logic mem_chan_out,
    output logic [31:0] mem_addr_out,
    output logic [15:0] mem_data_out,
    output logic irq_out,
    output logic wait_expired_out
);
    // Pending setup, copied to active on launch except settle_ms and timeout_ms, which are used directly.
    logic [31:0] memsize, posttrig, settle_ms, timeout_ms, act_size, act_post;
    logic [3:0] chen, act_chen;
    logic interlace, act_ilace, irq_en;
    logic [31:0] next_memsize, next_posttrig, next_settle_ms, next_timeout_ms;
    logic [31:0] next_act_size, next_act_post;
    logic [3:0] next_chen, next_act_chen;
    logic next_interlace, next_act_ilace, next_irq_en;
    arc_state_t state, next_state;
    logic [31:0] wr_ptr, cnt, ms_cnt, ms_left, next_wr_ptr, next_cnt, next_ms_cnt, next_ms_left;
    logic [1:0] phase, next_phase;
    logic irq, expired, next_irq, next_expired;
    logic trig_s1, trig_s2;
    logic [31:0] gran, maxpost, wval_size, wval_post;
    logic launch, halt, store, f_ready, f_valid;
    logic [35:0] f_din, f_dout;
    logic [15:0] pick;
    logic pick_chan;
    logic [31:0] rdata;

    // Round down to the step, clamp to the limit, never below one step.
    function automatic logic [31:0] snap(input logic [31:0] v, input logic [31:0] g,
                                         input logic [31:0] lim);
        logic [31:0] r;
        r = v & ~(g - 32'h0000_0001);
        if (r > lim) begin
            r = lim;
        end
        if (r < g) begin
            r = g;
        end
        return r;
    endfunction

    always_comb begin
        case (chen)
            ARC_CH_ALL: gran = ARC_GRAN_16;
            ARC_CH_01: gran = SINGLE_MODULES ? ARC_GRAN_32 : ARC_GRAN_16;
            default: gran = ARC_GRAN_32;
        endcase
        case (chen)
            ARC_CH_ALL: maxpost = ARC_MAX_POST_4CH;
            ARC_CH_01, ARC_CH_02: maxpost = ARC_MAX_POST_2CH;
            default: maxpost = ARC_MAX_POST_1CH;
        endcase
        wval_size = snap(reg_wdata_in, gran, 32'hFFFF_FFE0);
        wval_post = snap(reg_wdata_in, gran, maxpost);
    end

    assign launch = reg_wr_in && reg_index_in == ARC_IDX_COMMAND
        && (reg_wdata_in == ARC_LAUNCH_CODE || reg_wdata_in == ARC_LAUNCH_IRQ_CODE);
    assign halt = reg_wr_in && reg_index_in == ARC_IDX_COMMAND && reg_wdata_in == ARC_HALT_CODE;

    // Setup registers, writable only while stopped.
    always_comb begin
        next_memsize = memsize;
        next_posttrig = posttrig;
        next_chen = chen;
        next_settle_ms = settle_ms;
        next_timeout_ms = timeout_ms;
        next_interlace = interlace;
        if (reg_wr_in && state == ARC_ST_IDLE) begin
            case (reg_index_in)
                ARC_IDX_MEMSIZE: next_memsize = wval_size;
                ARC_IDX_POSTTRIG: next_posttrig = wval_post;
                ARC_IDX_CHENABLE: next_chen = reg_wdata_in[3:0];
                ARC_IDX_SETTLE: next_settle_ms = reg_wdata_in;
                ARC_IDX_TIMEOUT: next_timeout_ms = reg_wdata_in;
                ARC_IDX_MODE: next_interlace = HAS_INTERLACE && reg_wdata_in[0];
                default: next_memsize = memsize;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            memsize <= ARC_RST_MEMSIZE;
            posttrig <= ARC_RST_POST;
            chen <= ARC_CH_0;
            settle_ms <= '0;
            timeout_ms <= '0;
            interlace <= 1'b0;
        end else begin
            memsize <= next_memsize;
            posttrig <= next_posttrig;
            chen <= next_chen;
            settle_ms <= next_settle_ms;
            timeout_ms <= next_timeout_ms;
            interlace <= next_interlace;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
        end else begin
            trig_s1 <= trigger_in;
            trig_s2 <= trig_s1;
        end
    end

    // A channel sample is stored only when the FIFO can take it; samples arriving while it is full are dropped.
    assign store = sample_valid_in && f_ready && state != ARC_ST_IDLE && state != ARC_ST_SETTLE;

    always_comb begin
        next_state = state;
        next_act_size = act_size;
        next_act_post = act_post;
        next_act_chen = act_chen;
        next_act_ilace = act_ilace;
        next_irq_en = irq_en;
        next_wr_ptr = wr_ptr;
        next_cnt = cnt;
        next_ms_cnt = ms_cnt;
        next_ms_left = ms_left;
        next_irq = irq && !reg_rd_in;
        next_expired = expired;
        if (store) begin
            next_wr_ptr = (wr_ptr + 32'h0000_0001 >= act_size) ? '0 : wr_ptr + 32'h0000_0001;
        end
        if (irq_en && timeout_ms != '0 && state != ARC_ST_IDLE) begin
            if (ms_cnt == 32'(MS_CYCLES - 1)) begin
                next_ms_cnt = '0;
                next_ms_left = ms_left - 32'h0000_0001;
            end else begin
                next_ms_cnt = ms_cnt + 32'h0000_0001;
            end
        end
        case (state)
            ARC_ST_IDLE: begin
                if (launch) begin
                    next_act_size = memsize;
                    next_act_post = posttrig;
                    next_act_chen = chen;
                    next_act_ilace = interlace && chen == ARC_CH_0;
                    next_irq_en = reg_wdata_in == ARC_LAUNCH_IRQ_CODE;
                    next_wr_ptr = '0;
                    next_cnt = '0;
                    next_ms_cnt = '0;
                    next_ms_left = timeout_ms;
                    next_expired = 1'b0;
                    next_state = (HAS_RELAYS && settle_ms != '0) ? ARC_ST_SETTLE : ARC_ST_PRE;
                end
            end
            ARC_ST_SETTLE: begin
                if (ms_cnt == 32'(MS_CYCLES - 1)) begin
                    next_ms_cnt = '0;
                    next_cnt = cnt + 32'h0000_0001;
                    if (cnt + 32'h0000_0001 >= settle_ms) begin
                        next_cnt = '0;
                        next_state = ARC_ST_PRE;
                    end
                end else begin
                    next_ms_cnt = ms_cnt + 32'h0000_0001;
                end
            end
            ARC_ST_PRE: begin
                if (store) begin
                    next_cnt = cnt + 32'h0000_0001;
                end
                if (cnt >= act_size - act_post) begin
                    next_state = ARC_ST_ARMED;
                end
            end
            ARC_ST_ARMED: begin
                if (trig_s2) begin
                    next_cnt = '0;
                    next_state = ARC_ST_POST;
                end
            end
            ARC_ST_POST: begin
                if (store) begin
                    next_cnt = cnt + 32'h0000_0001;
                    if (cnt + 32'h0000_0001 >= act_post) begin
                        next_state = ARC_ST_IDLE;
                        next_irq = irq_en;
                    end
                end
            end
            default: next_state = ARC_ST_IDLE;
        endcase
        if (state != ARC_ST_IDLE && irq_en && timeout_ms != '0 && ms_left == '0) begin
            next_expired = 1'b1;
            next_state = ARC_ST_IDLE;
        end
        if (halt) begin
            next_state = ARC_ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state <= ARC_ST_IDLE;
            act_size <= ARC_RST_MEMSIZE;
            act_post <= ARC_RST_POST;
            act_chen <= ARC_CH_0;
            act_ilace <= 1'b0;
            irq_en <= 1'b0;
            wr_ptr <= '0;
            cnt <= '0;
            ms_cnt <= '0;
            ms_left <= '0;
            irq <= 1'b0;
            expired <= 1'b0;
            phase <= '0;
        end else begin
            state <= next_state;
            act_size <= next_act_size;
            act_post <= next_act_post;
            act_chen <= next_act_chen;
            act_ilace <= next_act_ilace;
            irq_en <= next_irq_en;
            wr_ptr <= next_wr_ptr;
            cnt <= next_cnt;
            ms_cnt <= next_ms_cnt;
            ms_left <= next_ms_left;
            irq <= next_irq;
            expired <= next_expired;
            phase <= next_phase;
        end
    end

    // Each store takes one channel sample; multi-channel sets step through phases.
    always_comb begin
        next_phase = (state == ARC_ST_IDLE) ? 2'h0 : phase;
        pick_chan = 1'b0;
        case (act_chen)
            ARC_CH_01: begin
                pick = {{4{sample_data_in[phase[0]*12+11]}}, sample_data_in[phase[0]*12 +: 12]};
                pick_chan = SINGLE_MODULES ? phase[0] : 1'b0;
            end
            ARC_CH_02: begin
                pick = {{4{sample_data_in[phase[0]*24+11]}}, sample_data_in[phase[0]*24 +: 12]};
                pick_chan = phase[0];
            end
            ARC_CH_ALL: begin
                pick = {{4{sample_data_in[phase*12+11]}}, sample_data_in[phase*12 +: 12]};
                pick_chan = phase[1];
            end
            default: begin
                pick = {{4{sample_data_in[11]}}, sample_data_in[11:0]};
                pick_chan = act_ilace ? ~wr_ptr[0] : 1'b0;
            end
        endcase
        if (store) begin
            next_phase = (act_chen == ARC_CH_ALL) ? phase + 2'h1 : {1'b0, ~phase[0]};
        end
        f_din = {pick_chan, 3'h0, pick, wr_ptr[15:0]};
    end

    arc_fifo #(.WIDTH(36), .DEPTH(ARC_FIFO_DEPTH)) u_fifo (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(store),
        .in_ready_out(f_ready),
        .in_data_in(f_din),
        .out_valid_out(f_valid),
        .out_ready_in(mem_ready_in),
        .out_data_out(f_dout)
    );

    assign mem_valid_out = f_valid;
    assign mem_chan_out = f_dout[35];
    assign mem_data_out = f_dout[31:16];
    assign mem_addr_out = {16'h0000, f_dout[15:0]};
    assign irq_out = irq;
    assign wait_expired_out = expired;

    always_comb begin
        case (reg_index_in)
            ARC_IDX_COMMAND: rdata = irq_en ? ARC_LAUNCH_IRQ_CODE : ARC_LAUNCH_CODE;
            ARC_IDX_STATUS: begin
                case (state)
                    ARC_ST_POST: rdata = ARC_TRIGGERED_STATE;
                    ARC_ST_IDLE: rdata = ARC_FINISHED_STATE;
                    default: rdata = ARC_ARMED_STATE;
                endcase
            end
            ARC_IDX_TIMEOUT: rdata = timeout_ms;
            ARC_IDX_MEMSIZE: rdata = memsize;
            ARC_IDX_POSTTRIG: rdata = posttrig;
            ARC_IDX_CHENABLE: rdata = {28'h0000000, chen};
            ARC_IDX_SETTLE: rdata = settle_ms;
            ARC_IDX_MODE: rdata = {31'h00000000, interlace};
            default: rdata = '0;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= rdata;
        end
    end
endmodule
`default_nettype wire

/* sim/arc_mem_model.sv */
// Memory-side model that logs sample words per memory channel.
// Assumes words are held until ready.
`timescale 1ns/100ps
`default_nettype none
module arc_mem_model (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic stall_in,
    input wire logic mem_valid_in,
    input wire logic mem_chan_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [15:0] mem_data_in,
    output logic mem_ready_out
);
    integer seed = 32'h1D3;
    logic [47:0] log0[$];
    logic [47:0] log1[$];
    initial mem_ready_out = 1'b0;
    // Random ready gaps emulate a busy memory.
    always @(posedge ref_clk_in) begin
        if (rst_n_in && mem_valid_in && mem_ready_out) begin
            if (mem_chan_in) begin
                log1.push_back({mem_addr_in, mem_data_in});
            end else begin
                log0.push_back({mem_addr_in, mem_data_in});
            end
        end
        mem_ready_out <= !stall_in && ($random(seed) % 4 != 0);
    end
endmodule
`default_nettype wire

/* sim/arc_run_checker.sv */
// Concurrent checks on the run control block's ports.
// Assumes one clock and synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module arc_run_checker
    import arc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_index_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic trigger_in,
    input wire logic sample_valid_in,
    input wire logic [47:0] sample_data_in,
    input wire logic mem_valid_out,
    input wire logic mem_ready_in,
    input wire logic mem_chan_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic [15:0] mem_data_out,
    input wire logic irq_out,
    input wire logic wait_expired_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic st_idx, cmd_wr, launch;
    assign st_idx = reg_index_in == ARC_IDX_STATUS;
    assign cmd_wr = reg_wr_in && reg_index_in == ARC_IDX_COMMAND;
    assign launch = cmd_wr &&
        (reg_wdata_in == ARC_LAUNCH_CODE || reg_wdata_in == ARC_LAUNCH_IRQ_CODE);
    a_reset_status: assert property (
        $rose(rst_n_in) && st_idx |=> reg_rdata_out == ARC_FINISHED_STATE)
        else $error("status not stopped after reset");
    a_unknown_zero: assert property (
        reg_index_in == 32'h0000_0001 |=> reg_rdata_out == 32'h0000_0000)
        else $error("unmapped index did not read zero");
    a_launch_armed: assert property (
        launch ##1 st_idx |=> reg_rdata_out == ARC_ARMED_STATE)
        else $error("launch did not arm the run");
    a_halt_stops: assert property (
        cmd_wr && reg_wdata_in == ARC_HALT_CODE ##1 st_idx |=> reg_rdata_out == ARC_FINISHED_STATE)
        else $error("halt did not stop the run");
    a_irq_clears: assert property (
        irq_out && reg_rd_in |=> !irq_out)
        else $error("read strobe did not clear interrupt");
    a_irq_holds: assert property (
        irq_out && !reg_rd_in |=> irq_out)
        else $error("interrupt dropped without a read");
    a_expired_holds: assert property (
        wait_expired_out && !launch |=> wait_expired_out)
        else $error("expiry flag dropped without a launch");
    a_expire_halts: assert property (
        $rose(wait_expired_out) && st_idx |=> reg_rdata_out == ARC_FINISHED_STATE)
        else $error("expiry did not stop the run");
    a_mem_stable: assert property (
        mem_valid_out && !mem_ready_in |=> mem_valid_out && $stable(mem_data_out) &&
        $stable(mem_chan_out) && $stable(mem_addr_out))
        else $error("memory word changed while stalled");
    c_launch: cover property (launch);
    c_irq: cover property ($rose(irq_out));
    c_expire: cover property ($rose(wait_expired_out));
endmodule
bind arc_run_control arc_run_checker u_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_index_in(reg_index_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .trigger_in(trigger_in),
    .sample_valid_in(sample_valid_in), .sample_data_in(sample_data_in),
    .mem_valid_out(mem_valid_out), .mem_ready_in(mem_ready_in), .mem_chan_out(mem_chan_out),
    .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out), .irq_out(irq_out),
    .wait_expired_out(wait_expired_out));
`default_nettype wire

/* sim/acquisition_run_control_tb.sv */
// Self-checking bench for the run control block.
// Assumes all core and sim files are compiled together.
`timescale 1ns/100ps
`default_nettype none
module acquisition_run_control_tb
    import arc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0, wr = 1'b0, rd = 1'b0, trig = 1'b0, sv = 1'b0, feed = 1'b0, stall = 1'b0;
    logic [31:0] idx = ARC_IDX_STATUS, wd = 32'h0, rdat, ma;
    logic [47:0] sd = 48'h0;
    logic mv, mr, mc, irq, expd;
    logic [15:0] mdat;
    integer seed = 32'h4B84;
    integer failures = 0, num_checks = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    arc_run_control #(.MS_CYCLES(10)) dut (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_index_in(idx), .reg_wdata_in(wd), .reg_rdata_out(rdat),
        .trigger_in(trig), .sample_valid_in(sv), .sample_data_in(sd), .mem_valid_out(mv),
        .mem_ready_in(mr), .mem_chan_out(mc), .mem_addr_out(ma), .mem_data_out(mdat),
        .irq_out(irq), .wait_expired_out(expd));
    arc_mem_model mem (.ref_clk_in(clk), .rst_n_in(rst_n), .stall_in(stall), .mem_valid_in(mv),
        .mem_chan_in(mc), .mem_addr_in(ma), .mem_data_in(mdat), .mem_ready_out(mr));
    // Bits 11:10 of each lane carry its number.
    always @(posedge clk) begin
        sv <= feed && ($random(seed) % 3 != 0);
        sd <= {2'h3, 10'($random(seed)), 2'h2, 10'($random(seed)),
               2'h1, 10'($random(seed)), 2'h0, 10'($random(seed))};
    end
    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [31:0] i, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        idx <= i;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        idx <= ARC_IDX_STATUS;
    endtask
    task automatic rd_reg(input logic [31:0] i, output logic [31:0] d);
        @(posedge clk);
        idx <= i;
        repeat (2) @(posedge clk);
        #1 d = rdat;
    endtask
    task automatic wait_state(input logic [31:0] s, input int lim);
        logic [31:0] v;
        v = 32'hFFFF_FFFF;
        for (int n = 0; n < lim && v !== s; n++) begin
            rd_reg(ARC_IDX_STATUS, v);
        end
        chk("run_state", s, v);
    endtask
    function automatic logic [31:0] gran(input logic [3:0] m);
        return (m == ARC_CH_ALL || m == ARC_CH_01) ? ARC_GRAN_16 : ARC_GRAN_32;
    endfunction
    function automatic logic [31:0] maxp(input logic [3:0] m);
        return m == ARC_CH_0 ? ARC_MAX_POST_1CH : m == ARC_CH_ALL ? ARC_MAX_POST_4CH :
            ARC_MAX_POST_2CH;
    endfunction
    task automatic setup(input logic [3:0] m, input logic [31:0] md, input logic [31:0] stl);
        logic [31:0] v;
        wr_reg(ARC_IDX_CHENABLE, {28'h0, m});
        wr_reg(ARC_IDX_MODE, md);
        wr_reg(ARC_IDX_SETTLE, stl);
        wr_reg(ARC_IDX_MEMSIZE, 32'h28);
        rd_reg(ARC_IDX_MEMSIZE, v);
        chk("record_length", 32'h20, v);
        wr_reg(ARC_IDX_POSTTRIG, 32'h8);
        rd_reg(ARC_IDX_POSTTRIG, v);
        chk("after_trigger_count", gran(m), v);
        wr_reg(ARC_IDX_POSTTRIG, 32'hFFFF_FFF0);
        rd_reg(ARC_IDX_POSTTRIG, v);
        chk("after_trigger_count", maxp(m), v);
        wr_reg(ARC_IDX_MEMSIZE, 32'h40);
        wr_reg(ARC_IDX_POSTTRIG, 32'h20);
    endtask
    task automatic check_routing(input logic [3:0] m, input logic il);
        logic [47:0] w;
        logic [1:0] ln;
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < (c ? mem.log1.size() : mem.log0.size()); i++) begin
                w = c ? mem.log1[i] : mem.log0[i];
                ln = 2'((m == ARC_CH_01 || m == ARC_CH_ALL) ? i % 2 : 0) +
                    ((c == 1 && !il) ? 2'h2 : 2'h0);
                chk("mem word", {25'h0, {4{ln[1]}}, ln,
                    il ? c == 0 : m == ARC_CH_02 ? c == 1 : i % 2 == 1},
                    {25'h0, w[15:10], w[16]});
            end
        end
        chk("chan1 used", 32'(m == ARC_CH_02 || m == ARC_CH_ALL || il),
            32'(mem.log1.size() != 0));
        chk("chan0 used", 32'h1, 32'(mem.log0.size() != 0));
        mem.log0.delete();
        mem.log1.delete();
    endtask
    task automatic run(input logic [3:0] m, input logic [31:0] md, input logic [31:0] code);
        logic [31:0] v;
        setup(m, md, 32'h0); // Setup precedes launch.
        trig <= 1'b1;
        wr_reg(ARC_IDX_COMMAND, code);
        repeat (20) @(posedge clk);
        rd_reg(ARC_IDX_STATUS, v);
        chk("run_state", ARC_ARMED_STATE, v);
        feed <= 1'b1;
        wait_state(ARC_TRIGGERED_STATE, 60);
        wait_state(ARC_FINISHED_STATE, 200);
        feed <= 1'b0;
        trig <= 1'b0;
        repeat (40) @(posedge clk);
        check_routing(m, md[0]);
    endtask
    initial begin
        #400000;
        failures++;
        final_report();
    end
    initial begin
        logic [31:0] v;
        logic [3:0] masks [4] = '{ARC_CH_0, ARC_CH_01, ARC_CH_02, ARC_CH_ALL};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(ARC_IDX_STATUS, v);
        chk("run_state", ARC_FINISHED_STATE, v);
        rd_reg(32'h0000_0001, v);
        chk("unmapped", 32'h0, v);
        for (int k = 0; k < 4; k++) begin
            run(masks[k], 32'h0, ARC_LAUNCH_CODE);
        end
        run(ARC_CH_0, 32'h1, ARC_LAUNCH_CODE);
        run(ARC_CH_0, 32'h0, ARC_LAUNCH_IRQ_CODE);
        #1 chk("irq", 32'h1, 32'(irq));
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1 chk("irq", 32'h0, 32'(irq));
        // Settle, then halt with memory stalled.
        setup(ARC_CH_0, 32'h0, 32'h1);
        stall <= 1'b1;
        feed <= 1'b1;
        wr_reg(ARC_IDX_COMMAND, ARC_LAUNCH_CODE);
        repeat (6) @(posedge clk);
        #1 chk("settle mv", 32'h0, 32'(mv));
        repeat (80) @(posedge clk);
        wr_reg(ARC_IDX_COMMAND, ARC_HALT_CODE);
        rd_reg(ARC_IDX_STATUS, v);
        chk("run_state", ARC_FINISHED_STATE, v);
        feed <= 1'b0;
        stall <= 1'b0;
        repeat (80) @(posedge clk);
        #1 chk("fifo filled", 32'h1, 32'(mem.log0.size() >= ARC_FIFO_DEPTH));
        chk("fifo drained", 32'h0, 32'(mv));
        // A 1 ms limit expires; zero waits on.
        setup(ARC_CH_0, 32'h0, 32'h0);
        wr_reg(ARC_IDX_TIMEOUT, 32'h1);
        rd_reg(ARC_IDX_TIMEOUT, v);
        chk("wait_limit_ms", 32'h1, v);
        feed <= 1'b1;
        wr_reg(ARC_IDX_COMMAND, ARC_LAUNCH_IRQ_CODE);
        repeat (40) @(posedge clk);
        #1 chk("expired", 32'h1, 32'(expd));
        rd_reg(ARC_IDX_STATUS, v);
        chk("run_state", ARC_FINISHED_STATE, v);
        wr_reg(ARC_IDX_TIMEOUT, 32'h0);
        wr_reg(ARC_IDX_COMMAND, ARC_LAUNCH_IRQ_CODE);
        repeat (80) @(posedge clk);
        #1 chk("expired", 32'h0, 32'(expd));
        rd_reg(ARC_IDX_STATUS, v);
        chk("run_state", ARC_ARMED_STATE, v);
        wr_reg(ARC_IDX_COMMAND, ARC_HALT_CODE);
        feed <= 1'b0;
        repeat (40) @(posedge clk);
        final_report();
    end
endmodule
`default_nettype wire
